/* ais_top.sv */
`timescale 1ns/1ps
// Contract
// (RULE1) buffer field n gives two to the n words per input, 1 to 128
// (RULE2) buffer-length register bits 15..3 read zero
// (RULE3) neg code 11 picks inputs 9-11, 10 picks 6-8, 0x negative reference
// (RULE4) sample B channel 1-3 negative select sits in bits 10..9
// (RULE5) sample A channel 1-3 negative select sits in bits 2..1
// (RULE6) bit 8 picks sample B positives: one gives 3-5, zero gives 0-2
// (RULE7) bit 0 picks sample A positives with the same coding
// (RULE8) in twelve-bit mode channel 1-3 fields act unimplemented, read zero
// (RULE9) channel 1-3 register bits 15..11 and 7..3 read zero
// (RULE10) channel 0 bit 7: one picks input 1, zero negative reference
// (RULE11) channel 0 bit 15 is sample B negative, same coding
// (RULE12) bits 4..0 pick channel 0 positive input by binary number
// (RULE13) bits 12..8 are sample B positive, same decoding
// (RULE14) second converter limits channel 0 positive to inputs 0..15
// (RULE15) scan bit one includes its input, zero skips it
// (RULE16) low scan bit n is input n, high scan bit n is input n+16
// (RULE17) all scan bits writable; absent inputs convert low reference
// (RULE18) resolution bit set: twelve-bit one channel; clear: ten-bit four
// (RULE19) scan enable steps channel 0 positive through mask in sample A
// (RULE20) alternate mode swaps A and B selects each sample, else A only
// (RULE21) scan visits enabled inputs ascending, wrapping to the lowest
module ais_top
  import ais_pkg::*;
#(
  parameter bit SECOND_UNIT = 1'b0,
  parameter int NUM_INPUTS = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AIS_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_advance,
  output ais_mux_s mux_sel,
  output logic [7:0] buffer_words_per_input
);

  logic [15:0] buflen_r;
  logic [15:0] chs123_r;
  logic [15:0] chs0_r;
  logic [15:0] scan_high_r;
  logic [15:0] scan_low_r;
  logic [15:0] mode_r;
  logic use_b_r;
  logic [4:0] scan_idx_r;
  logic [31:0] scan_mask;
  logic resolution_mode;
  logic scan_enable_ctrl;
  logic alternate_sample_mode;
  logic wr_fire;
  logic [15:0] wdata16;
  logic [31:0] rd_nxt;
  logic rd_err_nxt;
  logic [4:0] pos_nxt;
  ais_mux_s mux_nxt;

  // reset image matches what ten-bit mode decodes to, so no false step
  localparam ais_mux_s MUX_RST = '{
    ch0_pos: 5'h00,
    ch0_pos_low_ref: 1'b0,
    ch0_neg_an1: 1'b0,
    ch123_pos_an3_5: 1'b0,
    ch123_neg_sel: 2'h0,
    ch123_active: 1'b1,
    twelve_bit: 1'b0,
    sample_b: 1'b0
  };

  function automatic logic reg_hit(input logic fire,
                                   input logic [AIS_AW-1:0] addr,
                                   input logic [AIS_AW-1:0] off);
    return fire && (addr == off);
  endfunction

  function automatic logic [4:0] next_scan(input logic [31:0] mask,
                                           input logic [4:0] cur);
    logic [4:0] cand;
    logic found;
    cand = cur;
    found = 1'b0;
    for (int i = 1; i <= 32; i++) begin
      if (!found && mask[5'(int'(cur) + i)]) begin // RULE21
        cand = 5'(int'(cur) + i);
        found = 1'b1;
      end
    end
    return cand;
  endfunction

  function automatic logic [4:0] limit_pos(input logic [4:0] p);
    return SECOND_UNIT ? (p & AIS_LOW16[4:0]) : p; // RULE14
  endfunction

  assign resolution_mode = mode_r[AIS_MODE_RES_BIT];
  assign scan_enable_ctrl = mode_r[AIS_MODE_SCAN_BIT];
  assign alternate_sample_mode = mode_r[AIS_MODE_ALT_BIT];
  assign wr_fire = psel && penable && pready && pwrite;
  assign wdata16 = pwdata[15:0];
  // second unit only scans its sixteen inputs
  assign scan_mask = SECOND_UNIT ? {AIS_RST16, scan_low_r}
                                 : {scan_high_r, scan_low_r}; // RULE16

  // register writes; the zero-wait slave commits at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buflen_r <= AIS_RST16;
    end else if (reg_hit(wr_fire, paddr, AIS_OFF_BUFLEN)) begin
      buflen_r <= wdata16 & AIS_BUFLEN_MASK; // RULE2
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chs123_r <= AIS_RST16;
    end else if (reg_hit(wr_fire, paddr, AIS_OFF_CHS123)) begin
      // writes dropped while the fields are unimplemented
      if (!resolution_mode) begin // RULE8
        chs123_r <= wdata16 & AIS_CHS123_MASK; // RULE9
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chs0_r <= AIS_RST16;
    end else if (reg_hit(wr_fire, paddr, AIS_OFF_CHS0)) begin
      chs0_r <= wdata16 & AIS_CHS0_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_high_r <= AIS_RST16;
    end else if (reg_hit(wr_fire, paddr, AIS_OFF_SCANH)) begin
      scan_high_r <= wdata16; // RULE17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_low_r <= AIS_RST16;
    end else if (reg_hit(wr_fire, paddr, AIS_OFF_SCANL)) begin
      scan_low_r <= wdata16; // RULE17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= AIS_RST16;
    end else if (reg_hit(wr_fire, paddr, AIS_OFF_MODE)) begin
      mode_r <= wdata16 & AIS_MODE_MASK;
    end
  end

  // read decode; data latched in the setup cycle
  always_comb begin
    rd_nxt = 32'h0000_0000;
    rd_err_nxt = 1'b0;
    case (paddr)
      AIS_OFF_BUFLEN: rd_nxt[15:0] = buflen_r; // RULE2
      AIS_OFF_CHS123: begin
        rd_nxt[15:0] = resolution_mode ? AIS_RST16 : chs123_r; // RULE8
      end
      AIS_OFF_CHS0: rd_nxt[15:0] = chs0_r;
      AIS_OFF_SCANH: rd_nxt[15:0] = scan_high_r;
      AIS_OFF_SCANL: rd_nxt[15:0] = scan_low_r;
      AIS_OFF_MODE: rd_nxt[15:0] = mode_r;
      AIS_OFF_STATUS: begin
        rd_nxt[AIS_ST_B_BIT] = use_b_r;
        rd_nxt[AIS_ST_IDX_LO +: 5] = scan_idx_r;
      end
      default: rd_err_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && rd_err_nxt;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_nxt;
      end
    end
  end

  // sample sequencing: alternation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      use_b_r <= 1'b0;
    end else if (sample_advance) begin
      use_b_r <= alternate_sample_mode && !use_b_r; // RULE20
    end else if (!alternate_sample_mode) begin
      use_b_r <= 1'b0; // RULE20
    end
  end

  // scan stepping; only moves after a sample A conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_idx_r <= AIS_IDX_ZERO;
    end else if (sample_advance && scan_enable_ctrl && !use_b_r) begin // RULE19
      scan_idx_r <= next_scan(scan_mask, scan_idx_r); // RULE15
    end
  end

  always_comb begin
    mux_nxt = '0;
    mux_nxt.sample_b = use_b_r;
    mux_nxt.twelve_bit = resolution_mode; // RULE18
    mux_nxt.ch123_active = !resolution_mode; // RULE18
    if (use_b_r) begin
      pos_nxt = chs0_r[AIS_FIRST_CHANNEL_POS_SELECT_B_LO +: 5]; // RULE13
      mux_nxt.ch0_neg_an1 = chs0_r[AIS_FIRST_CHANNEL_NEG_SELECT_B_BIT]; // RULE11
      mux_nxt.ch123_pos_an3_5 = chs123_r[AIS_SB_BIT]; // RULE6
      mux_nxt.ch123_neg_sel = chs123_r[AIS_NB_LO +: 2]; // RULE4
    end else begin
      pos_nxt = scan_enable_ctrl ? scan_idx_r
                                 : chs0_r[AIS_FIRST_CHANNEL_POS_SELECT_A_LO +: 5]; // RULE12
      mux_nxt.ch0_neg_an1 = chs0_r[AIS_FIRST_CHANNEL_NEG_SELECT_A_BIT]; // RULE10
      mux_nxt.ch123_pos_an3_5 = chs123_r[AIS_SA_BIT]; // RULE7
      mux_nxt.ch123_neg_sel = chs123_r[AIS_NA_LO +: 2]; // RULE5
    end
    // codes 0x both mean negative reference; fold to one code
    if (mux_nxt.ch123_neg_sel != AIS_NEG_AN9_11 &&
        mux_nxt.ch123_neg_sel != AIS_NEG_AN6_8) begin // RULE3
      mux_nxt.ch123_neg_sel = 2'h0;
    end
    if (resolution_mode) begin // RULE8
      mux_nxt.ch123_pos_an3_5 = 1'b0;
      mux_nxt.ch123_neg_sel = 2'h0;
    end
    mux_nxt.ch0_pos = limit_pos(pos_nxt); // RULE14
    mux_nxt.ch0_pos_low_ref = int'(mux_nxt.ch0_pos) >= NUM_INPUTS; // RULE17
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_sel <= MUX_RST;
    end else begin
      mux_sel <= mux_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_words_per_input <= 8'h01;
    end else begin
      buffer_words_per_input <= 8'(8'h01 << buflen_r[2:0]); // RULE1
    end
  end

endmodule

/* ais_pkg.sv */
package ais_pkg;
  localparam int AIS_AW = 8;
  localparam logic [AIS_AW-1:0] AIS_OFF_BUFLEN = 8'h00;
  localparam logic [AIS_AW-1:0] AIS_OFF_CHS123 = 8'h04;
  localparam logic [AIS_AW-1:0] AIS_OFF_CHS0 = 8'h08;
  localparam logic [AIS_AW-1:0] AIS_OFF_SCANH = 8'h0c;
  localparam logic [AIS_AW-1:0] AIS_OFF_SCANL = 8'h10;
  localparam logic [AIS_AW-1:0] AIS_OFF_MODE = 8'h14;
  localparam logic [AIS_AW-1:0] AIS_OFF_STATUS = 8'h18;
  localparam logic [15:0] AIS_RST16 = 16'h0000;
  // buffer-length register
  localparam logic [15:0] AIS_BUFLEN_MASK = 16'h0007;
  // channel 1-3 select fields
  localparam logic [15:0] AIS_CHS123_MASK = 16'h0707;
  localparam int AIS_NB_LO = 9;
  localparam int AIS_SB_BIT = 8;
  localparam int AIS_NA_LO = 1;
  localparam int AIS_SA_BIT = 0;
  // channel 0 select fields
  localparam logic [15:0] AIS_CHS0_MASK = 16'h9f9f;
  localparam int AIS_FIRST_CHANNEL_NEG_SELECT_B_BIT = 15;
  localparam int AIS_FIRST_CHANNEL_POS_SELECT_B_LO = 8;
  localparam int AIS_FIRST_CHANNEL_NEG_SELECT_A_BIT = 7;
  localparam int AIS_FIRST_CHANNEL_POS_SELECT_A_LO = 0;
  // mode register
  localparam logic [15:0] AIS_MODE_MASK = 16'h0007;
  localparam int AIS_MODE_RES_BIT = 0;
  localparam int AIS_MODE_SCAN_BIT = 1;
  localparam int AIS_MODE_ALT_BIT = 2;
  // status register
  localparam int AIS_ST_B_BIT = 0;
  localparam int AIS_ST_IDX_LO = 8;
  // negative selects for channels 1-3
  localparam logic [1:0] AIS_NEG_AN9_11 = 2'b11;
  localparam logic [1:0] AIS_NEG_AN6_8 = 2'b10;
  localparam logic [15:0] AIS_LOW16 = 16'h000f;
  localparam logic [4:0] AIS_IDX_ZERO = 5'h00;

  typedef struct packed {
    logic [4:0] ch0_pos;
    logic ch0_pos_low_ref;
    logic ch0_neg_an1;
    logic ch123_pos_an3_5;
    logic [1:0] ch123_neg_sel;
    logic ch123_active;
    logic twelve_bit;
    logic sample_b;
  } ais_mux_s;
endpackage

/* ais_top_asserts.sv */
`timescale 1ns/1ps
module ais_chk
  import ais_pkg::*;
#(
  parameter int NUM_INPUTS = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AIS_AW-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire ais_mux_s mux_sel,
  input wire logic [7:0] buffer_words_per_input
);
  wire rd = psel && penable && pready && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // no wait states, so a late ready is already a fault
  AST_READY: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  AST_BUFW: assert property (rd && paddr == AIS_OFF_BUFLEN |->
    buffer_words_per_input == 8'h1 << prdata[2:0]) else $error("bad words");
  AST_BUFRD: assert property (rd && paddr == AIS_OFF_BUFLEN |->
    prdata[31:3] == 0) else $error("buffer length high bits set");
  AST_C123RD: assert property (rd && paddr == AIS_OFF_CHS123 |->
    prdata == (prdata & {16'h0, AIS_CHS123_MASK})) else $error("ch123 bits");
  AST_C0RD: assert property (rd && paddr == AIS_OFF_CHS0 |->
    prdata == (prdata & {16'h0, AIS_CHS0_MASK})) else $error("ch0 bits");
  AST_TWELVE: assert property (mux_sel.twelve_bit |->
    mux_sel.ch123_neg_sel == 0 && !mux_sel.ch123_pos_an3_5)
    else $error("ch123 select live in twelve-bit mode");
  AST_RES: assert property (mux_sel.ch123_active != mux_sel.twelve_bit)
    else $error("channel count wrong for mode");
  AST_NEG: assert property (mux_sel.ch123_neg_sel != 2'b01)
    else $error("negative code not folded");
  AST_LOWREF: assert property (mux_sel.ch0_pos_low_ref ==
    (mux_sel.ch0_pos >= NUM_INPUTS)) else $error("low reference flag");
endmodule
bind ais_top ais_chk #(.NUM_INPUTS(NUM_INPUTS)) ais_chk_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .mux_sel(mux_sel),
  .buffer_words_per_input(buffer_words_per_input));

/* ais_top_bench.sv */
`timescale 1ns/1ps
module ais_top_bench;
  import ais_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic sample_advance = 0, err;
  logic [AIS_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr;
  logic [4:0] cur;
  ais_mux_s mux_sel;
  logic [7:0] buffer_words_per_input;
  int fails = 0, n_tests = 0;
  always #5 pclk = ~pclk;
  ais_top ais_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_advance(sample_advance), .mux_sel(mux_sel),
    .buffer_words_per_input(buffer_words_per_input));
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // two idle edges after release so mux outputs have caught up
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) fails++;
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    repeat (2) @(posedge pclk);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk("read", q, e);
  endtask
  task adv;
    sample_advance <= 1;
    @(posedge pclk);
    sample_advance <= 0;
    repeat (2) @(posedge pclk);
  endtask
  function automatic logic [4:0] nxt(logic [4:0] c);
    int j;
    for (int k = 1; k <= 32; k++) begin
      j = (c + k) % 32;
      if (32'h0001_0012 >> j & 1) return 5'(j);
    end
    return c;
  endfunction
  task t_basic;
    chk("act0", mux_sel.ch123_active, 1);
    chk("w0", buffer_words_per_input, 1);
    for (int k = 0; k < 5; k++) rdc(8'(k * 4), 0);
    for (int k = 0; k < 8; k++) begin
      apb(1, AIS_OFF_BUFLEN, 32'hfff8 | k);
      rdc(AIS_OFF_BUFLEN, k);
      chk("words", buffer_words_per_input, 32'h1 << k);
    end
    apb(0, 8'h1c, 0);
    chk("slverr", err, 1);
    $display("test basic done");
  endtask
  task t_ch123;
    apb(1, AIS_OFF_CHS123, 32'hffff);
    rdc(AIS_OFF_CHS123, 32'h0707);
    for (int k = 0; k < 4; k++) begin
      apb(1, AIS_OFF_CHS123, (k << 1) | (k & 1));
      chk("neg", mux_sel.ch123_neg_sel, k > 1 ? k : 0);
      chk("pos", mux_sel.ch123_pos_an3_5, k & 1);
    end
    $display("test ch123 done");
  endtask
  task t_alt;
    apb(1, AIS_OFF_CHS123, 32'h0700);
    apb(1, AIS_OFF_CHS0, 32'h9516);
    chk("p0", mux_sel.ch0_pos, 5'h16);
    chk("n0", mux_sel.ch0_neg_an1, 0);
    apb(1, AIS_OFF_MODE, 4);
    adv;
    chk("b", mux_sel.sample_b, 1);
    chk("p0b", mux_sel.ch0_pos, 5'h15);
    chk("n0b", mux_sel.ch0_neg_an1, 1);
    chk("nb", mux_sel.ch123_neg_sel, 3);
    chk("pb", mux_sel.ch123_pos_an3_5, 1);
    adv;
    chk("a", mux_sel.sample_b, 0);
    apb(1, AIS_OFF_MODE, 1);
    rdc(AIS_OFF_CHS123, 0);
    chk("act", mux_sel.ch123_active, 0);
    chk("twelve", mux_sel.twelve_bit, 1);
    apb(1, AIS_OFF_CHS123, 1);
    apb(1, AIS_OFF_MODE, 0);
    rdc(AIS_OFF_CHS123, 32'h0700);
    $display("test alternate done");
  endtask
  task t_scan;
    apb(1, AIS_OFF_SCANL, 32'h0012);
    apb(1, AIS_OFF_SCANH, 32'h0001);
    rdc(AIS_OFF_SCANH, 1);
    apb(1, AIS_OFF_MODE, 2);
    apb(0, AIS_OFF_STATUS, 0);
    cur = q[12:8];
    repeat (4) begin
      cur = nxt(cur);
      adv;
      chk("scan", mux_sel.ch0_pos, cur);
      chk("lowref", mux_sel.ch0_pos_low_ref, 0);
    end
    $display("test scan done");
  endtask
  initial begin
    #100us;
    fails++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_basic;
    t_ch123;
    t_alt;
    t_scan;
    report_and_stop;
  end
endmodule
